// [hdl/pbsp_mem.sv]
// storage array with lane write enables and registered read data
// assumes writes and reads are gated by the caller's enable
`timescale 1ns/1ps
module pbsp_mem
  import pbsp_pkg::*;
(
  // clock and enable
  input wire logic mclk,
  input wire logic en,
  // write side
  input wire logic wr_en,
  input wire logic [pbsp_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [pbsp_pkg::LANES-1:0] wr_lanes,
  input wire logic [pbsp_pkg::WORD_W-1:0] wr_data,
  // read side
  input wire logic [pbsp_pkg::ADDR_W-1:0] rd_addr,
  output logic [pbsp_pkg::WORD_W-1:0] rd_data
);
  import pbsp_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LANE_W-1:0] store [DEPTH];
      // lane write, unselected lanes untouched
      always_ff @(posedge mclk)
      begin
        if (en && wr_en && wr_lanes[g])
        begin
          store[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
        if (en)
        begin
          rd_data[g*LANE_W +: LANE_W] <= store[rd_addr];
        end
      end
    end
  endgenerate

endmodule // pbsp_mem

// [hdl/pbsp_pkg.sv]
// constants and state layout for the pipelined burst memory port
// assumes one clock, synchronous inputs, 36-bit word in four 9-bit lanes
package pbsp_pkg;

  // word and lane shape
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = 32;
  localparam int WORD_W = LANES * LANE_W;
  // array depth kept small for simulation
  localparam int ADDR_W = 8;
  localparam int BURST_W = 2;

  // third select not bonded out in ball-grid parts
  localparam logic THIRD_SELECT_BONDED = 1'b0;

  // values after reset, plus the all-lanes write mask
  localparam logic [BURST_W-1:0] CNT_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;

  // whole state of the port
  typedef struct packed {
    logic selected;
    logic interleaved;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] cnt;
    logic rd_valid;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lanes;
    logic [WORD_W-1:0] wr_data;
  } pbsp_state_type;

endpackage

// [hdl/pbsp_port.sv]
// pin-level port of a pipelined synchronous burst static memory
// assumes host drives synchronous pins off mclk; data pins resolved outside
`timescale 1ns/1ps
module pbsp_port
  import pbsp_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // address and strobes
  input wire logic [pbsp_pkg::ADDR_W-1:0] address,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  // chip selects
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  // write controls
  input wire logic all_lanes_write_n,
  input wire logic byte_write_qualifier_n,
  input wire logic [pbsp_pkg::LANES-1:0] lane_write_select_n,
  // asynchronous controls and strap
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  // data pins
  input wire logic [pbsp_pkg::DATA_W-1:0] dq_in,
  output logic [pbsp_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  // parity pins
  input wire logic [pbsp_pkg::LANES-1:0] parity_lines_in,
  output logic [pbsp_pkg::LANES-1:0] parity_lines_out,
  output logic parity_lines_oe
);
  import pbsp_pkg::*;

  pbsp_state_type st;
  pbsp_state_type next_st;

  logic run;
  logic sel_now;
  logic third_active;
  logic processor_addr_strobe_n_load;
  logic controller_addr_strobe_n_load;
  logic load;
  logic eff_sel;
  logic write_req;
  logic wr_cycle;
  logic rd_next;
  logic [BURST_W-1:0] burst_low;
  logic [ADDR_W-1:0] cur_addr;
  logic [LANES-1:0] lanes_req;
  logic [WORD_W-1:0] pin_word;
  logic [WORD_W-1:0] rd_word;
  logic drive;

  // burst order: interleaved xor, linear add
  function automatic logic [BURST_W-1:0] burst_step(
    input logic inter,
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count
  );
    burst_step = inter ? (start ^ count) : BURST_W'(start + count);
  endfunction

  assign run = clk_en && !sleep_request;

  // third select absent in ball-grid build
  assign third_active = THIRD_SELECT_BONDED ? !chip_select_third_n : 1'b1;
  assign sel_now = !chip_select_first_n && chip_select_second && third_active;

  // processor strobe masked by first select
  assign processor_addr_strobe_n_load = !processor_addr_strobe_n && !chip_select_first_n;
  assign controller_addr_strobe_n_load = !controller_addr_strobe_n && !processor_addr_strobe_n_load;
  assign load = processor_addr_strobe_n_load || controller_addr_strobe_n_load;

  // selects only count on load cycles
  assign eff_sel = load ? sel_now : st.selected;

  always_comb
  begin
    lanes_req = LANES_NONE;
    if (!all_lanes_write_n)
    begin
      lanes_req = LANES_ALL;
    end
    else if (!byte_write_qualifier_n)
    begin
      lanes_req = ~lane_write_select_n;
    end
  end

  assign write_req = |lanes_req;
  // write controls ignored on processor-strobe load cycle
  assign wr_cycle = eff_sel && !processor_addr_strobe_n_load && write_req;

  assign burst_low = burst_step(st.interleaved, st.base[BURST_W-1:0], st.cnt);
  assign cur_addr = {st.base[ADDR_W-1:BURST_W], burst_low};

  // no data in first cycle out of deselect
  // deselecting load drops the output stage
  assign rd_next = st.selected && !wr_cycle && !(load && !sel_now);

  // lane packing of pins into stored word
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_pack
      assign pin_word[g*LANE_W +: LANE_W] = {parity_lines_in[g], dq_in[g*8 +: 8]};
      assign dq_out[g*8 +: 8] = rd_word[g*LANE_W +: 8];
      assign parity_lines_out[g] = rd_word[g*LANE_W + 8];
    end
  endgenerate

  // next state applied only on rising edge
  always_comb
  begin
    next_st = st;
    if (run)
    begin
      if (load)
      begin
        next_st.selected = sel_now;
        next_st.base = address;
        next_st.cnt = CNT_RESET;
      end
      else if (st.selected && !burst_advance_n)
      begin
        next_st.cnt = BURST_W'(st.cnt + 2'h1);
      end
      // read data valid the clock after capture
      next_st.rd_valid = rd_next;
      next_st.wr_pend = wr_cycle;
      if (wr_cycle)
      begin
        next_st.wr_addr = load ? address : cur_addr;
        next_st.wr_lanes = lanes_req;
        next_st.wr_data = pin_word;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st.selected <= 1'b0;
      st.interleaved <= burst_order_strap;
      st.base <= ADDR_RESET;
      st.cnt <= CNT_RESET;
      st.rd_valid <= 1'b0;
      st.wr_pend <= 1'b0;
      st.wr_addr <= ADDR_RESET;
      st.wr_lanes <= LANES_NONE;
      st.wr_data <= WORD_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  pbsp_mem u_mem (
    .mclk(mclk),
    .en(run),
    .wr_en(st.wr_pend),
    .wr_addr(st.wr_addr),
    .wr_lanes(st.wr_lanes),
    .wr_data(st.wr_data),
    .rd_addr(cur_addr),
    .rd_data(rd_word)
  );

  assign drive = !output_enable_n && !sleep_request && st.rd_valid && !wr_cycle;
  assign dq_oe = drive;
  assign parity_lines_oe = drive;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_processor_addr_strobe_n_take;
    run && !processor_addr_strobe_n && !chip_select_first_n;
  endsequence

  sequence s_emerge_read;
    run && load && sel_now && !st.selected && !wr_cycle;
  endsequence

  sequence s_read_issue;
    run && st.selected && !load && !wr_cycle;
  endsequence

  sequence s_write_issue;
    run && wr_cycle;
  endsequence

  a_burst_advance: assert property (
    (run && !load && st.selected && !burst_advance_n)
    |=> st.cnt == BURST_W'($past(st.cnt) + 2'h1))
    else $error("burst counter did not advance");

  a_burst_hold: assert property (
    (run && !load && burst_advance_n)
    |=> st.cnt == $past(st.cnt) && st.base == $past(st.base))
    else $error("burst state changed without advance");

  a_addr_latch: assert property (
    (run && load) |=> st.base == $past(address) && st.cnt == CNT_RESET)
    else $error("address not latched on strobe");

  a_processor_addr_strobe_n_masked: assert property (
    (run && !processor_addr_strobe_n && chip_select_first_n && controller_addr_strobe_n)
    |=> st.base == $past(st.base) && st.selected == $past(st.selected))
    else $error("processor strobe taken with first select high");

  a_strobe_priority: assert property (
    (s_processor_addr_strobe_n_take and (!controller_addr_strobe_n && !all_lanes_write_n))
    |=> !st.wr_pend)
    else $error("controller strobe honoured over processor strobe");

  a_select_ignored: assert property (
    (run && !load) |=> st.selected == $past(st.selected))
    else $error("selects sampled outside load");

  a_deselect_tri: assert property (
    (run && load && !sel_now) |=> !st.selected && !dq_oe ##1 !(run && !load) || !dq_oe)
    else $error("deselect did not tri-state outputs");

  a_first_read_mask: assert property (
    s_emerge_read |=> !dq_oe && !parity_lines_oe)
    else $error("outputs driven in first cycle out of deselect");

  a_read_latency: assert property (
    s_read_issue ##1 (!output_enable_n && !sleep_request && !wr_cycle) |-> dq_oe)
    else $error("read data not driven one clock after capture");

  a_oe_async: assert property (
    (output_enable_n || sleep_request) |-> !dq_oe && !parity_lines_oe)
    else $error("outputs driven while disabled");

  a_write_tristate: assert property (
    wr_cycle |-> !dq_oe)
    else $error("outputs driven during write cycle");

  a_global_write: assert property (
    (s_write_issue and !all_lanes_write_n) |=> st.wr_pend && st.wr_lanes == LANES_ALL)
    else $error("global write missed a lane");

  a_lane_write: assert property (
    (s_write_issue and all_lanes_write_n)
    |=> st.wr_lanes == ~$past(lane_write_select_n))
    else $error("lane selects not honoured");

  a_data_capture: assert property (
    s_write_issue |=> st.wr_data == $past(pin_word))
    else $error("write data not captured");

  a_sleep_freeze: assert property (
    sleep_request |=> st == $past(st))
    else $error("state moved during sleep");

  a_freeze_enable: assert property (
    (!clk_en) |=> st == $past(st))
    else $error("state moved with clock enable low");

endmodule // pbsp_port

// [tb/pbsp_host.sv]
// host-side pin model for the burst memory port
// assumes pins sampled at rising mclk; all changes made at falling mclk
`timescale 1ns/1ps
module pbsp_host
(
  // clock
  input wire logic mclk,
  // address and strobes
  output logic [pbsp_pkg::ADDR_W-1:0] addr,
  output logic pstrobe_n,
  output logic cstrobe_n,
  output logic step_n,
  // selects
  output logic sel1_n,
  output logic sel2,
  // write controls
  output logic all_n,
  output logic qual_n,
  output logic [pbsp_pkg::LANES-1:0] lane_n,
  // data
  output logic [pbsp_pkg::WORD_W-1:0] wdata,
  output logic drv
);
  import pbsp_pkg::*;

  initial
  begin
    {pstrobe_n, cstrobe_n, sel1_n, sel2, all_n, qual_n, step_n, drv} = 8'hde;
    addr = 8'h00;
    lane_n = 4'hf;
    wdata = 36'h0_0000_0000;
  end

  // pins move only at the falling edge
  task automatic drive(input logic [3:0] st, input logic [7:0] a, input logic [3:0] wr,
    input logic [3:0] ln, input logic [35:0] d);
    @(negedge mclk);
    {pstrobe_n, cstrobe_n, sel1_n, sel2} = st;
    {all_n, qual_n, step_n, drv} = wr;
    addr = a;
    lane_n = ln;
    // new write data only with drv set; otherwise last data inverted
    wdata = wr[0] ? d : ~wdata;
  endtask
endmodule // pbsp_host

// [tb/pbsp_port_tb_top.sv]
// self-checking bench for the burst memory port
// assumes host model drives pins; bench resolves the shared data pins
`timescale 1ns/1ps
module pbsp_port_tb_top;
  import pbsp_pkg::*;
  logic mclk, rst, oe_n, sleep, strap, third_n, clk_en;
  logic [ADDR_W-1:0] addr;
  logic ps_n, cs_n, step_n, sel1_n, sel2, all_n, qual_n, drv, d_oe, p_oe;
  logic [LANES-1:0] lane_n, p_out;
  logic [DATA_W-1:0] d_out;
  logic [WORD_W-1:0] wdata, bus;
  int failures, compares;

  assign bus = drv ? wdata : ((d_oe & p_oe) ? {p_out, d_out} : wdata);

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  pbsp_host host (.mclk(mclk), .addr(addr), .pstrobe_n(ps_n), .cstrobe_n(cs_n),
    .step_n(step_n), .sel1_n(sel1_n), .sel2(sel2), .all_n(all_n), .qual_n(qual_n),
    .lane_n(lane_n), .wdata(wdata), .drv(drv));

  pbsp_port uut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .address(addr),
    .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
    .burst_advance_n(step_n), .chip_select_first_n(sel1_n), .chip_select_second(sel2),
    .chip_select_third_n(third_n), .all_lanes_write_n(all_n),
    .byte_write_qualifier_n(qual_n), .lane_write_select_n(lane_n),
    .output_enable_n(oe_n), .sleep_request(sleep), .burst_order_strap(strap),
    .dq_in(bus[31:0]), .dq_out(d_out), .dq_oe(d_oe), .parity_lines_in(bus[35:32]),
    .parity_lines_out(p_out), .parity_lines_oe(p_oe));

  function automatic logic [35:0] pat(input logic [7:0] a);
    return {a[3:0], ~a, a, 8'h3c, a ^ 8'ha5};
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
    input logic [3:0] ln);
    logic [35:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (!ln[i])
      begin
        r[8*i+:8] = n[8*i+:8];
        r[32+i] = n[32+i];
      end
    end
    return r;
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_oe(input logic e);
    check(36'({d_oe, p_oe}), 36'({e, e}));
  endtask

  task automatic step(input logic [3:0] st, input logic [7:0] a, input logic [3:0] wr,
    input logic [3:0] ln, input logic [35:0] d);
    host.drive(st, a, wr, ln, d);
    @(posedge mclk);
    #1;
  endtask

  task automatic idle();
    step(4'hd, 8'h00, 4'he, 4'hf, 36'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] w, input logic [3:0] ln,
    input logic [35:0] d);
    step(4'h9, a, w, ln, d);
    idle();
  endtask

  task automatic rd(input logic [7:0] a, input logic [35:0] e[$]);
    step(4'h5, a, 4'he, 4'hf, 36'h0);
    foreach (e[k])
    begin
      step(4'he, a, 4'hc, 4'hf, 36'h0);
      check({p_out, d_out}, e[k]);
    end
  endtask

  task automatic s_burst();
    for (int i = 16; i < 20; i++)
      wr(8'(i), 4'h7, 4'hf, pat(8'(i)));
    rd(8'h11, {pat(8'h11), pat(8'h12), pat(8'h13), pat(8'h10)});
    chk_oe(1'b1);
    @(negedge mclk);
    oe_n = 1'b1;
    #1;
    chk_oe(1'b0);
    oe_n = 1'b0;
    sleep = 1'b1;
    #1;
    chk_oe(1'b0);
    wr(8'h10, 4'h7, 4'hf, 36'h0);
    @(negedge mclk);
    sleep = 1'b0;
    rd(8'h10, {pat(8'h10)});
    // clock enable low: write must be lost
    @(negedge mclk);
    clk_en = 1'b0;
    wr(8'h11, 4'h7, 4'hf, 36'h0);
    @(negedge mclk);
    clk_en = 1'b1;
    rd(8'h11, {pat(8'h11)});
  endtask

  task automatic s_inter();
    @(negedge mclk);
    strap = 1'b1;
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    rd(8'h11, {pat(8'h11), pat(8'h10), pat(8'h13), pat(8'h12)});
  endtask

  task automatic s_prio();
    step(4'h1, 8'h12, 4'h7, 4'hf, 36'h0);
    idle();
    rd(8'h12, {pat(8'h12)});
    step(4'h5, 8'h12, 4'he, 4'hf, 36'h0);
    host.drive(4'hd, 8'h12, 4'h7, 4'hf, 36'h9_1234_5678);
    #1;
    chk_oe(1'b0);
    @(posedge mclk);
    idle();
    idle();
    rd(8'h12, {36'h9_1234_5678});
  endtask

  task automatic s_select();
    rd(8'h13, {pat(8'h13)});
    step(4'h7, 8'h00, 4'he, 4'hf, 36'h0);
    chk_oe(1'b1);
    step(4'h8, 8'h00, 4'he, 4'hf, 36'h0);
    chk_oe(1'b0);
    step(4'h5, 8'h13, 4'he, 4'hf, 36'h0);
    chk_oe(1'b0);
    rd(8'h13, {pat(8'h13)});
    step(4'hb, 8'h00, 4'he, 4'hf, 36'h0);
    chk_oe(1'b0);
  endtask

  task automatic s_lanes();
    wr(8'h10, 4'hb, 4'ha, 36'hf_0123_4567);
    wr(8'h10, 4'hf, 4'h0, 36'h0);
    rd(8'h10, {merge(pat(8'h10), 36'hf_0123_4567, 4'ha)});
  endtask

  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    oe_n = 1'b0;
    sleep = 1'b0;
    strap = 1'b0;
    // third select left inactive on purpose
    third_n = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    s_burst();
    s_inter();
    s_prio();
    s_select();
    s_lanes();
    final_report();
  end

  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule // pbsp_port_tb_top
